// >>> daisy_pkg.sv
// constants, state layouts and register map of the bus port and interrupt daisy chain
package daisy_pkg;
	// ==========================================
	// device register map (2-bit register address)
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_CMD = 2'h1;
	localparam logic [1:0] REG_VECTOR = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	// control register fields
	localparam int CTRL_IRQ_EN = 0;
	localparam int CTRL_CHAIN_BLOCK = 1;
	// command register fields
	localparam int CMD_CLR_PENDING = 0;
	localparam int CMD_CLR_SERVICE = 1;
	// status register fields
	localparam int STAT_PENDING = 0;
	localparam int STAT_SERVICE = 1;
	localparam int STAT_CHAIN_IN = 2;
	localparam int STAT_IRQ_EN = 3;
	localparam int STAT_CHAIN_BLOCK = 4;
	localparam logic [7:0] VECTOR_RESET = 8'h00;
	// synchroniser: select, read, store, acknowledge
	localparam int SYNC_BITS = 4;
	localparam int SYNC_CS = 0;
	localparam int SYNC_RD = 1;
	localparam int SYNC_WR = 2;
	localparam int SYNC_ACK = 3;
	// ==========================================
	// host controller register map (3-bit address)
	localparam logic [2:0] HREG_TARGET = 3'h0;
	localparam logic [2:0] HREG_WDATA = 3'h1;
	localparam logic [2:0] HREG_CMD = 3'h2;
	localparam logic [2:0] HREG_STATUS = 3'h3;
	localparam logic [2:0] HREG_RDATA = 3'h4;
	// command codes written to HREG_CMD
	localparam logic [1:0] HCMD_WRITE = 2'h0;
	localparam logic [1:0] HCMD_READ = 2'h1;
	localparam logic [1:0] HCMD_ACK = 2'h2;
	localparam logic [1:0] HCMD_RESET = 2'h3;
	localparam int HSTAT_BUSY = 0;
	localparam int HSTAT_IRQ = 1;
	// ==========================================
	// bus timing
	localparam int CLK_NS = 5;
	localparam int STROBE_NS = 40;
	localparam int RECOVER_NS = 20;
	localparam logic [3:0] STROBE_CYCLES = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RECOVER_CYCLES = 4'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RECOVER} host_state_e;
endpackage

// >>> periph_bus_if.sv
// interface joining the host controller and the peripheral bus port
`timescale 1ns/1ps
interface periph_bus_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic irq_ack_n;
	logic host_io_request_n;
	logic [1:0] addr;
	logic [7:0] host_data_out;
	logic host_data_oe;
	logic [7:0] dev_data_out;
	logic dev_data_oe;
	logic [7:0] data;
	logic dev_int_out;
	logic dev_int_oe;
	logic int_n;
	logic chain_enable_in;
	logic chain_enable_out;
	// wire resolution: pull-up on the data bus and on the open-drain request
	assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);
	assign int_n = dev_int_oe ? dev_int_out : 1'b1;
	modport device (input cs_n, rd_n, wr_n, irq_ack_n, addr, data, chain_enable_in,
		output dev_data_out, dev_data_oe, dev_int_out, dev_int_oe, chain_enable_out);
	modport host (input data, int_n,
		output cs_n, rd_n, wr_n, irq_ack_n, host_io_request_n, addr, host_data_out, host_data_oe);
endinterface

// >>> strobe_sync.sv
// two-stage synchroniser for the asynchronous bus strobes
`timescale 1ns/1ps
module strobe_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// strobes in and out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ==========================================
	// per-bit chain; strobes are idle high, so reset to one
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta;
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				meta <= 1'b1;
				sync_out[i] <= 1'b1;
			end else if (ce) begin
				meta <= async_in[i];
				sync_out[i] <= meta; // only the second stage reads the first
			end
		end
	end
endmodule // strobe_sync

// >>> periph_device.sv
// peripheral end: register port, strobe-coincidence reset and daisy-chain interrupt logic
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module periph_device (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// peripheral bus
	periph_bus_if.device bus,
	// user side: interrupt sources and flag view
	input wire logic service_event,
	input wire logic service_done,
	output logic pending_flag,
	output logic in_service_flag
);
	typedef struct packed {
		logic rd_act;
		logic wr_act;
		logic ack_act;
		logic vec_drive;
		logic pending;
		logic in_service;
		logic irq_enable;
		logic chain_block;
		logic [7:0] vector;
		logic [7:0] data_out;
		logic data_oe;
		logic chain_out;
		logic irq_drive;
	} dev_state_s;

	localparam dev_state_s RESET_STATE = '{
		rd_act: 1'b0, wr_act: 1'b0, ack_act: 1'b0, vec_drive: 1'b0,
		pending: 1'b0, in_service: 1'b0, irq_enable: 1'b0, chain_block: 1'b0,
		vector: daisy_pkg::VECTOR_RESET, data_out: 8'h00, data_oe: 1'b0,
		chain_out: 1'b0, irq_drive: 1'b0
	};

	dev_state_s s;
	dev_state_s next_s;
	logic [daisy_pkg::SYNC_BITS-1:0] strobe_raw;
	logic [daisy_pkg::SYNC_BITS-1:0] strobe_s;
	logic sel_s;
	logic rd_s;
	logic wr_s;
	logic ack_s;
	logic rd_now;
	logic wr_now;
	logic ack_now;
	logic chip_reset;
	logic ack_grant;
	logic [7:0] reg_read;

	// ==========================================
	// strobe synchronisation
	// the peripheral clock has no phase relation to the strobes
	assign strobe_raw[daisy_pkg::SYNC_CS] = bus.cs_n;
	assign strobe_raw[daisy_pkg::SYNC_RD] = bus.rd_n;
	assign strobe_raw[daisy_pkg::SYNC_WR] = bus.wr_n;
	assign strobe_raw[daisy_pkg::SYNC_ACK] = bus.irq_ack_n;

	strobe_sync #(
		.WIDTH(daisy_pkg::SYNC_BITS)
	) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.async_in(strobe_raw),
		.sync_out(strobe_s)
	);

	// active-high views of the synchronised strobes
	assign sel_s = ~strobe_s[daisy_pkg::SYNC_CS];
	assign rd_s = ~strobe_s[daisy_pkg::SYNC_RD];
	assign wr_s = ~strobe_s[daisy_pkg::SYNC_WR];
	assign ack_s = ~strobe_s[daisy_pkg::SYNC_ACK];

	// ==========================================
	// access qualification
	// accesses last only while select and strobe overlap
	assign rd_now = sel_s & rd_s & ~ack_s & ~wr_s;
	assign wr_now = sel_s & wr_s & ~rd_s;
	// acknowledge reads need no select; the chain decides who answers
	assign ack_now = ack_s & rd_s & ~wr_s;
	// both strobes low at once is the only reset the bus can give
	assign chip_reset = rd_s & wr_s;
	// only a device with chain input high, pending and not yet served answers
	assign ack_grant = bus.chain_enable_in & s.pending & ~s.in_service;

	// ==========================================
	// register read mux, decoded on the stable address
	always_comb begin
		reg_read = 8'h00;
		if (bus.addr == daisy_pkg::REG_CTRL) begin
			reg_read[daisy_pkg::CTRL_IRQ_EN] = s.irq_enable;
			reg_read[daisy_pkg::CTRL_CHAIN_BLOCK] = s.chain_block;
		end else if (bus.addr == daisy_pkg::REG_VECTOR) begin
			reg_read = s.vector;
		end else if (bus.addr == daisy_pkg::REG_STATUS) begin
			reg_read[daisy_pkg::STAT_PENDING] = s.pending;
			reg_read[daisy_pkg::STAT_SERVICE] = s.in_service;
			reg_read[daisy_pkg::STAT_CHAIN_IN] = bus.chain_enable_in;
			reg_read[daisy_pkg::STAT_IRQ_EN] = s.irq_enable;
			reg_read[daisy_pkg::STAT_CHAIN_BLOCK] = s.chain_block;
		end
	end

	// ==========================================
	// next-state logic
	always_comb begin
		next_s = s;
		next_s.rd_act = rd_now;
		next_s.wr_act = wr_now;
		next_s.ack_act = ack_now;

		// pending: the source's set wins over any clear in the same cycle
		if (wr_now && !s.wr_act && bus.addr == daisy_pkg::REG_CMD && bus.data[daisy_pkg::CMD_CLR_PENDING]) begin
			next_s.pending = 1'b0;
		end
		if (service_done) begin
			next_s.pending = 1'b0;
		end
		if (service_event) begin
			next_s.pending = 1'b1;
		end

		// store strobe: capture the bus once, at the start of the overlap
		if (wr_now && !s.wr_act) begin
			if (bus.addr == daisy_pkg::REG_CTRL) begin
				next_s.irq_enable = bus.data[daisy_pkg::CTRL_IRQ_EN];
				next_s.chain_block = bus.data[daisy_pkg::CTRL_CHAIN_BLOCK];
			end else if (bus.addr == daisy_pkg::REG_CMD) begin
				if (bus.data[daisy_pkg::CMD_CLR_SERVICE]) begin
					next_s.in_service = 1'b0; // only software clears it
				end
			end else if (bus.addr == daisy_pkg::REG_VECTOR) begin
				next_s.vector = bus.data;
			end
		end

		// acknowledge: decide once at the leading edge, then hold for the cycle
		if (ack_now && !s.ack_act) begin
			next_s.vec_drive = ack_grant;
			if (ack_grant) begin
				next_s.in_service = 1'b1;
			end
		end else if (!ack_now) begin
			next_s.vec_drive = 1'b0;
		end

		// data bus: vector in acknowledge, register otherwise, else released
		if (ack_now && next_s.vec_drive) begin
			next_s.data_out = s.vector;
			next_s.data_oe = 1'b1;
		end else if (rd_now) begin
			next_s.data_out = reg_read;
			next_s.data_oe = 1'b1;
		end else begin
			next_s.data_oe = 1'b0;
		end

		// chain out, active high, feeds the next lower device
		if (s.chain_block) begin
			next_s.chain_out = 1'b0;
		end else if (ack_s) begin
			next_s.chain_out = bus.chain_enable_in & ~s.pending & ~s.in_service;
		end else begin
			next_s.chain_out = bus.chain_enable_in & ~s.in_service;
		end

		// request: may drop but not rise during acknowledge so the chain can settle
		if (!ack_s) begin
			next_s.irq_drive = s.irq_enable & s.pending & ~s.in_service & bus.chain_enable_in;
		end else if (!(s.pending && !s.in_service)) begin
			next_s.irq_drive = 1'b0; // dropping is allowed, raising is not
		end

		if (chip_reset) begin
			next_s = RESET_STATE;
		end
	end

	// ==========================================
	// state register, frozen while ce is low
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= RESET_STATE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ==========================================
	// outputs, all straight from the state register
	assign bus.dev_data_out = s.data_out;
	assign bus.dev_data_oe = s.data_oe;
	// open drain: the driven level is always low, only the enable moves
	assign bus.dev_int_out = s.rd_act & 1'b0;
	assign bus.dev_int_oe = s.irq_drive;
	assign bus.chain_enable_out = s.chain_out;
	assign pending_flag = s.pending;
	assign in_service_flag = s.in_service;
endmodule // periph_device

// >>> periph_host.sv
// host end: runs select, read, store, acknowledge and reset cycles from a register port
`timescale 1ns/1ps
module periph_host (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// peripheral bus
	periph_bus_if.host bus,
	// software register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	typedef struct packed {
		daisy_pkg::host_state_e state;
		logic [1:0] op;
		logic [3:0] count;
		logic [1:0] target;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [7:0] rdout;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ack_n;
		logic io_req_n;
		logic data_oe;
	} host_state_s;

	localparam host_state_s RESET_STATE = '{
		state: daisy_pkg::H_IDLE, op: daisy_pkg::HCMD_WRITE, count: 4'h0, target: 2'h0,
		wdata: 8'h00, rdata: 8'h00, rdout: 8'h00, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		ack_n: 1'b1, io_req_n: 1'b1, data_oe: 1'b0
	};

	host_state_s s;
	host_state_s next_s;
	logic uses_select;

	assign uses_select = (s.op == daisy_pkg::HCMD_WRITE) || (s.op == daisy_pkg::HCMD_READ);

	// ==========================================
	// register port and cycle sequencer
	always_comb begin
		next_s = s;
		// read data stand in the cycle after the read strobe
		next_s.rdout = 8'h00;
		if (reg_rd) begin
			if (reg_addr == daisy_pkg::HREG_TARGET) begin
				next_s.rdout = {6'h00, s.target};
			end else if (reg_addr == daisy_pkg::HREG_WDATA) begin
				next_s.rdout = s.wdata;
			end else if (reg_addr == daisy_pkg::HREG_STATUS) begin
				next_s.rdout[daisy_pkg::HSTAT_BUSY] = (s.state != daisy_pkg::H_IDLE);
				next_s.rdout[daisy_pkg::HSTAT_IRQ] = ~bus.int_n;
			end else if (reg_addr == daisy_pkg::HREG_RDATA) begin
				next_s.rdout = s.rdata;
			end
		end
		// target and data are frozen while a cycle runs so the bus stays stable
		if (reg_wr && s.state == daisy_pkg::H_IDLE) begin
			if (reg_addr == daisy_pkg::HREG_TARGET) begin
				next_s.target = reg_wdata[1:0];
			end else if (reg_addr == daisy_pkg::HREG_WDATA) begin
				next_s.wdata = reg_wdata;
			end else if (reg_addr == daisy_pkg::HREG_CMD) begin
				next_s.op = reg_wdata[1:0];
				next_s.state = daisy_pkg::H_SETUP;
			end
		end

		case (s.state)
			daisy_pkg::H_IDLE: begin
				next_s.count = 4'h0;
			end
			daisy_pkg::H_SETUP: begin
				// select only in our own I/O cycle
				next_s.io_req_n = ~uses_select;
				next_s.cs_n = ~uses_select;
				next_s.ack_n = (s.op != daisy_pkg::HCMD_ACK); // settled before the read strobe
				next_s.data_oe = (s.op == daisy_pkg::HCMD_WRITE); // data ahead of the store strobe
				next_s.state = daisy_pkg::H_STROBE;
			end
			daisy_pkg::H_STROBE: begin
				next_s.rd_n = (s.op == daisy_pkg::HCMD_WRITE);
				next_s.wr_n = (s.op == daisy_pkg::HCMD_READ) || (s.op == daisy_pkg::HCMD_ACK);
				next_s.count = s.count + 4'h1;
				if (s.count == daisy_pkg::STROBE_CYCLES) begin
					next_s.rd_n = 1'b1;
					next_s.wr_n = 1'b1;
					next_s.rdata = bus.data;
					next_s.count = 4'h0;
					next_s.state = daisy_pkg::H_RECOVER;
				end
			end
			daisy_pkg::H_RECOVER: begin
				// hold select, address and acknowledge until the strobe release is seen
				next_s.count = s.count + 4'h1;
				if (s.count == daisy_pkg::RECOVER_CYCLES) begin
					next_s.cs_n = 1'b1;
					next_s.io_req_n = 1'b1;
					next_s.ack_n = 1'b1;
					next_s.data_oe = 1'b0;
					next_s.count = 4'h0;
					next_s.state = daisy_pkg::H_IDLE;
				end
			end
			default: begin
				next_s.state = daisy_pkg::H_IDLE;
			end
		endcase
	end

	// ==========================================
	// state register, frozen while ce is low
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= RESET_STATE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ==========================================
	// outputs from the state register
	assign bus.cs_n = s.cs_n;
	assign bus.rd_n = s.rd_n;
	assign bus.wr_n = s.wr_n;
	assign bus.irq_ack_n = s.ack_n;
	assign bus.host_io_request_n = s.io_req_n;
	assign bus.addr = s.target;
	assign bus.host_data_out = s.wdata;
	assign bus.host_data_oe = s.data_oe;
	assign reg_rdata = s.rdout;
endmodule // periph_host

// >>> periph_bus_irq_daisy_chain_asserts.sv
// concurrent checks on the bus joining the host end and the device end
`timescale 1ns/1ps
module periph_bus_irq_daisy_chain_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// bus strobes and address
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic irq_ack_n,
	input wire logic host_io_request_n,
	input wire logic [1:0] addr,
	// drivers of the shared lines
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic dev_int_out,
	input wire logic dev_int_oe,
	// daisy chain
	input wire logic chain_enable_in,
	input wire logic chain_enable_out,
	// device flag view
	input wire logic pending_flag
);
	// ==========================================
	// single clock domain, so clocking and reset are given once
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// a selected read long enough for the synchroniser to settle
	sequence read_overlap_s;
		(!cs_n && !rd_n && irq_ack_n) [*6];
	endsequence
	sequence ack_held_s;
		(!irq_ack_n) [*4];
	endsequence
	sequence ack_blocked_s;
		(!irq_ack_n && !chain_enable_in) [*4];
	endsequence
	// ==========================================
	// checks
	int_open_drain_a: assert property (dev_int_oe |-> !dev_int_out)
		else $error("request line driven high");
	read_drive_a: assert property (read_overlap_s |-> dev_data_oe)
		else $error("selected read not answered");
	drive_cause_a: assert property (dev_data_oe |-> (!$past(rd_n, 2) || !$past(rd_n, 3) || !$past(rd_n, 4)))
		else $error("device drives data outside a read");
	sync_delay_a: assert property ($rose(dev_data_oe) |-> !$past(rd_n) && !$past(rd_n, 2))
		else $error("data driven before strobe synchronised");
	no_clash_a: assert property (dev_data_oe |-> !host_data_oe)
		else $error("both ends drive the data bus");
	ack_no_vector_a: assert property (ack_blocked_s |-> !dev_data_oe)
		else $error("vector driven with chain input low");
	ack_no_raise_a: assert property (ack_held_s |-> !$rose(dev_int_oe))
		else $error("request raised during acknowledge");
	chain_follow_a: assert property (chain_enable_out |-> $past(chain_enable_in))
		else $error("chain output high with chain input low");
	chip_reset_a: assert property ((!rd_n && !wr_n) [*5] |-> !dev_int_oe)
		else $error("request survives strobe reset");
	data_setup_a: assert property ($fell(wr_n) && !cs_n |-> host_data_oe && $past(host_data_oe))
		else $error("write data not set up before store strobe");
	addr_hold_a: assert property ((!rd_n || !wr_n) && $past(!rd_n || !wr_n) |-> $stable(addr) && $stable(irq_ack_n))
		else $error("address or acknowledge moved in a cycle");
	select_qual_a: assert property (!cs_n |-> !host_io_request_n)
		else $error("select without own I/O request");
	// chain output lags the synchronised acknowledge and the pending flag by one edge
	ack_chain_a: assert property (ack_held_s |-> !chain_enable_out || !$past(pending_flag))
		else $error("chain output high in acknowledge with pending set");
endmodule // periph_bus_irq_daisy_chain_asserts

// >>> periph_bus_irq_daisy_chain_tb_top.sv
// self-checking bench: host end drives the device end across the bus
`timescale 1ns/1ps
module periph_bus_irq_daisy_chain_tb_top;
	logic core_clk;
	logic rstn;
	logic ce;
	logic service_event;
	logic service_done;
	logic pending_flag;
	logic in_service_flag;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] rd_val;
	int mismatches;
	int compares;
	// ==========================================
	// the two ends, joined by the interface
	periph_bus_if periph_bus_if_inst ();
	periph_host periph_host_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce), .bus(periph_bus_if_inst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	periph_device periph_device_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce), .bus(periph_bus_if_inst),
		.service_event(service_event), .service_done(service_done), .pending_flag(pending_flag),
		.in_service_flag(in_service_flag));
	periph_bus_irq_daisy_chain_asserts periph_bus_irq_daisy_chain_asserts_inst (.core_clk(core_clk), .rstn(rstn),
		.cs_n(periph_bus_if_inst.cs_n), .rd_n(periph_bus_if_inst.rd_n), .wr_n(periph_bus_if_inst.wr_n),
		.irq_ack_n(periph_bus_if_inst.irq_ack_n), .host_io_request_n(periph_bus_if_inst.host_io_request_n),
		.addr(periph_bus_if_inst.addr),
		.host_data_oe(periph_bus_if_inst.host_data_oe), .dev_data_oe(periph_bus_if_inst.dev_data_oe),
		.dev_int_out(periph_bus_if_inst.dev_int_out), .dev_int_oe(periph_bus_if_inst.dev_int_oe),
		.chain_enable_in(periph_bus_if_inst.chain_enable_in),
		.chain_enable_out(periph_bus_if_inst.chain_enable_out), .pending_flag(pending_flag));
	// ==========================================
	// clock, 5 ns period
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ==========================================
	// tasks
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// one bus cycle: target, data, command, then poll busy under a bound
	task automatic bus_op(input logic [1:0] op, input logic [1:0] tgt, input logic [7:0] d);
		int n;
		reg_write(daisy_pkg::HREG_TARGET, {6'h00, tgt});
		reg_write(daisy_pkg::HREG_WDATA, d);
		reg_write(daisy_pkg::HREG_CMD, {6'h00, op});
		rd_val = 8'h01;
		for (n = 0; n < 40 && rd_val[daisy_pkg::HSTAT_BUSY] !== 1'b0; n++) begin
			reg_read(daisy_pkg::HREG_STATUS, rd_val);
		end
		check("host busy", {7'h00, rd_val[daisy_pkg::HSTAT_BUSY]}, 8'h00);
	endtask
	task automatic dev_rd(input logic [1:0] op, input logic [1:0] tgt, input logic [7:0] exp, input string name);
		bus_op(op, tgt, 8'h00);
		reg_read(daisy_pkg::HREG_RDATA, rd_val);
		check(name, rd_val, exp);
	endtask
	task automatic pulse(input logic done);
		@(posedge core_clk);
		service_event <= !done;
		service_done <= done;
		@(posedge core_clk);
		service_event <= 1'b0;
		service_done <= 1'b0;
		tick(4);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// watchdog: the tests need a few hundred cycles
	initial begin
		#200000;
		mismatches++;
		$display("watchdog expired");
		finish_test();
	end
	// ==========================================
	// main sequence
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		service_event = 1'b0;
		service_done = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mismatches = 0;
		compares = 0;
		periph_bus_if_inst.chain_enable_in = 1'b1;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_STATUS, 8'h04, "status at reset");
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_VECTOR, daisy_pkg::VECTOR_RESET, "vector at reset");
		check("chain out idle", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h01);
		$display("test reset_values done");
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_VECTOR, 8'ha5);
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_VECTOR, 8'ha5, "vector readback");
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_CMD, 8'h00, "command reads zero");
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_CTRL, 8'h01);
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_STATUS, 8'h0c, "status enabled");
		$display("test store_read done");
		pulse(1'b0);
		check("request low", {7'h00, periph_bus_if_inst.int_n}, 8'h00);
		check("chain out pending", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h01);
		@(posedge core_clk);
		periph_bus_if_inst.chain_enable_in <= 1'b0;
		tick(4);
		check("request chain low", {7'h00, periph_bus_if_inst.int_n}, 8'h01);
		check("chain out follows", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h00);
		dev_rd(daisy_pkg::HCMD_ACK, 2'h0, 8'hff, "ack chain low");
		check("service chain low", {7'h00, in_service_flag}, 8'h00);
		@(posedge core_clk);
		periph_bus_if_inst.chain_enable_in <= 1'b1;
		tick(4);
		dev_rd(daisy_pkg::HCMD_ACK, 2'h0, 8'ha5, "vector on ack");
		check("service set", {7'h00, in_service_flag}, 8'h01);
		check("pending kept", {7'h00, pending_flag}, 8'h01);
		check("chain out served", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h00);
		check("request served", {7'h00, periph_bus_if_inst.int_n}, 8'h01);
		dev_rd(daisy_pkg::HCMD_ACK, 2'h0, 8'hff, "second ack silent");
		pulse(1'b1);
		check("pending done", {7'h00, pending_flag}, 8'h00);
		check("service held", {7'h00, in_service_flag}, 8'h01);
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_CMD, 8'h02);
		check("service cleared", {7'h00, in_service_flag}, 8'h00);
		check("chain out back", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h01);
		pulse(1'b0);
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_CMD, 8'h01);
		check("pending cmd clear", {7'h00, pending_flag}, 8'h00);
		$display("test acknowledge done");
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_CTRL, 8'h03);
		check("chain blocked", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h00);
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_STATUS, 8'h1c, "status blocked");
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_CTRL, 8'h03, "control blocked");
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_CTRL, 8'h01);
		check("chain unblocked", {7'h00, periph_bus_if_inst.chain_enable_out}, 8'h01);
		$display("test chain_block done");
		// clock enable low: a one-cycle event must be missed, all state frozen
		@(posedge core_clk);
		ce <= 1'b0;
		pulse(1'b0);
		check("event while frozen", {7'h00, pending_flag}, 8'h00);
		@(posedge core_clk);
		ce <= 1'b1;
		$display("test clock_enable done");
		bus_op(daisy_pkg::HCMD_WRITE, daisy_pkg::REG_VECTOR, 8'h5a);
		reg_read(daisy_pkg::HREG_WDATA, rd_val);
		check("host write data", rd_val, 8'h5a);
		reg_read(daisy_pkg::HREG_TARGET, rd_val);
		check("host target", rd_val, 8'h02);
		pulse(1'b0);
		check("request before reset", {7'h00, periph_bus_if_inst.int_n}, 8'h00);
		reg_read(daisy_pkg::HREG_STATUS, rd_val);
		check("host sees request", rd_val, 8'h02);
		bus_op(daisy_pkg::HCMD_RESET, 2'h0, 8'h00);
		check("request after reset", {7'h00, periph_bus_if_inst.int_n}, 8'h01);
		check("pending after reset", {7'h00, pending_flag}, 8'h00);
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_VECTOR, 8'h00, "vector after reset");
		dev_rd(daisy_pkg::HCMD_READ, daisy_pkg::REG_STATUS, 8'h04, "status after reset");
		$display("test chip_reset done");
		finish_test();
	end
endmodule // periph_bus_irq_daisy_chain_tb_top
